/* rtl/sps_top.v */
`timescale 1ns/1ps
`include "sps_defines.vh"

module sps_top (
    clock,
    rst,
    clk_en,
    step_clk,
    excitation_select,
    edge_select,
    rotation_dir,
    sys_reset_n,
    output_enable,
    open_detect,
    overcurrent_detect,
    overheat_detect,
    supply_low,
    phase_one,
    phase_one_inverse,
    phase_two,
    phase_two_inverse,
    any_fault_n_out,
    any_fault_n_oe,
    fault_kind_level,
    s_axi_awaddr,
    s_axi_awprot,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arprot,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready
);
    input  wire        clock;
    input  wire        rst;
    input  wire        clk_en;
    input  wire        step_clk;
    input  wire        excitation_select;
    input  wire        edge_select;
    input  wire        rotation_dir;
    input  wire        sys_reset_n;
    input  wire        output_enable;
    input  wire        open_detect;
    input  wire        overcurrent_detect;
    input  wire        overheat_detect;
    input  wire        supply_low;
    output reg         phase_one;
    output reg         phase_one_inverse;
    output reg         phase_two;
    output reg         phase_two_inverse;
    output wire        any_fault_n_out;
    output wire        any_fault_n_oe;
    output reg  [1:0]  fault_kind_level;
    input  wire [3:0]  s_axi_awaddr;
    input  wire [2:0]  s_axi_awprot;
    input  wire        s_axi_awvalid;
    output wire        s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output wire        s_axi_wready;
    output reg  [1:0]  s_axi_bresp;
    output reg         s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [3:0]  s_axi_araddr;
    input  wire [2:0]  s_axi_arprot;
    input  wire        s_axi_arvalid;
    output wire        s_axi_arready;
    output reg  [31:0] s_axi_rdata;
    output reg  [1:0]  s_axi_rresp;
    output reg         s_axi_rvalid;
    input  wire        s_axi_rready;

    wire [`SPS_PIN_WIDTH-1:0] pins_s;
    reg                       step_prev_q;
    reg                       reset_prev_q;
    reg  [2:0]                pos_q;
    reg  [2:0]                pos_d;
    reg  [2:0]                fault_q;
    reg  [31:0]               ctrl_q;
    reg  [31:0]               step_count_q;
    reg  [3:0]                awaddr_q;
    reg                       aw_held_q;
    reg  [31:0]               wdata_q;
    reg  [3:0]                wstrb_q;
    reg                       w_held_q;
    reg  [31:0]               rd_word;
    reg                       rd_ok;

    wire step_s      = pins_s[`SPS_PIN_STEP];
    wire reset_n_s   = pins_s[`SPS_PIN_RESET_N];
    wire supply_lo_s = pins_s[`SPS_PIN_SUPPLY_LOW];
    wire step_rise   = step_s & ~step_prev_q;
    wire step_fall   = ~step_s & step_prev_q;
    wire step_take   = step_rise | (step_fall & ~pins_s[`SPS_PIN_EDGE]);
    wire reset_rel   = reset_n_s & ~reset_prev_q;
    wire any_fault   = |fault_q;
    wire driving     = pins_s[`SPS_PIN_ENABLE] & ctrl_q[`SPS_CTRL_SW_ENABLE] & ~any_fault;
    wire [2:0] fault_evt = {pins_s[`SPS_PIN_OVERHEAT], pins_s[`SPS_PIN_OVERCURRENT],
                            pins_s[`SPS_PIN_OPEN]};
    wire aw_go       = s_axi_awvalid & s_axi_awready;
    wire w_go        = s_axi_wvalid & s_axi_wready;
    wire ar_go       = s_axi_arvalid & s_axi_arready;
    wire wr_addr_ok  = aw_held_q ? 1'b1 : aw_go;
    wire wr_data_ok  = w_held_q ? 1'b1 : w_go;
    wire wr_fire     = wr_addr_ok & wr_data_ok & ~s_axi_bvalid;
    wire [3:0]  wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;

    // Half-step table: even positions energise two phases, odd positions one.
    // Order is A, inverse A, B, inverse B in the returned vector.
    function [3:0] sps_phase_map;
        input [2:0] pos;
        begin
            case (pos)
                3'h0:    sps_phase_map = 4'b1001;
                3'h1:    sps_phase_map = 4'b1000;
                3'h2:    sps_phase_map = 4'b1010;
                3'h3:    sps_phase_map = 4'b0010;
                3'h4:    sps_phase_map = 4'b0110;
                3'h5:    sps_phase_map = 4'b0100;
                3'h6:    sps_phase_map = 4'b0101;
                3'h7:    sps_phase_map = 4'b0001;
                default: sps_phase_map = 4'b0000;
            endcase
        end
    endfunction

    function [31:0] sps_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer      i;
        begin
            sps_merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    sps_merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    sps_sync u_sync (
        .clock    (clock),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in ({supply_low, overheat_detect, overcurrent_detect, open_detect,
                    output_enable, sys_reset_n, rotation_dir, edge_select,
                    excitation_select, step_clk}),
        .sync_out (pins_s)
    );

    // Next position. In two-phase mode an odd position moves one step, which
    // lands on the nearest two-phase state instead of restarting the cycle.
    always @* begin
        pos_d = pos_q;
        if (step_take) begin
            if (pins_s[`SPS_PIN_EXCITE] | pos_q[0]) begin
                pos_d = pins_s[`SPS_PIN_DIR] ? pos_q - 3'h1 : pos_q + 3'h1;
            end else begin
                pos_d = pins_s[`SPS_PIN_DIR] ? pos_q - 3'h2 : pos_q + 3'h2;
            end
        end
    end

    // Sequencer. The pin reset and the low-supply flag both hold the start
    // state; stepping goes on while outputs are off so timing is kept.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            step_prev_q  <= 1'b0;
            reset_prev_q <= 1'b0;
            pos_q        <= `SPS_POS_INITIAL;
            step_count_q <= 32'h0000_0000;
        end else if (clk_en) begin
            step_prev_q  <= step_s;
            reset_prev_q <= reset_n_s;
            if (~reset_n_s | supply_lo_s) begin
                pos_q <= `SPS_POS_INITIAL;
            end else begin
                pos_q <= pos_d;
            end
            if (wr_fire && wr_addr == `SPS_CTRL_OFFSET && wr_strb[0] &&
                wr_data[`SPS_CTRL_COUNT_CLEAR]) begin
                step_count_q <= 32'h0000_0000;
            end else if (step_take && reset_n_s && !supply_lo_s) begin
                step_count_q <= step_count_q + 32'h0000_0001;
            end
        end
    end

    // Fault latch. A new event wins over the clearing reset release.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            fault_q <= 3'h0;
        end else if (clk_en) begin
            if (supply_lo_s) begin
                fault_q <= 3'h0;
            end else if (reset_rel) begin
                fault_q <= fault_evt;
            end else begin
                fault_q <= fault_q | fault_evt;
            end
        end
    end

    // Registered pin outputs. Overheat has the highest level and wins when
    // several faults are latched together.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_one         <= 1'b0;
            phase_one_inverse <= 1'b0;
            phase_two         <= 1'b0;
            phase_two_inverse <= 1'b0;
            fault_kind_level  <= `SPS_KIND_NONE;
        end else if (clk_en) begin
            if (driving && reset_n_s && !supply_lo_s) begin
                {phase_one, phase_one_inverse, phase_two, phase_two_inverse}
                    <= sps_phase_map(pos_q);
            end else begin
                {phase_one, phase_one_inverse, phase_two, phase_two_inverse}
                    <= 4'b0000;
            end
            if (fault_q[2]) begin
                fault_kind_level <= `SPS_KIND_OVERHEAT;
            end else if (fault_q[1]) begin
                fault_kind_level <= `SPS_KIND_OVERCURRENT;
            end else if (fault_q[0]) begin
                fault_kind_level <= `SPS_KIND_OPEN;
            end else begin
                fault_kind_level <= `SPS_KIND_NONE;
            end
        end
    end

    // Open-drain summary flag, driven low while a fault is latched.
    assign any_fault_n_out = 1'b0;
    assign any_fault_n_oe  = any_fault;

    // Readies drop with the clock enable so no beat is taken while frozen.
    assign s_axi_awready = clk_en & ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready  = clk_en & ~w_held_q & ~s_axi_bvalid;
    assign s_axi_arready = clk_en & ~s_axi_rvalid;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            awaddr_q     <= 4'h0;
            aw_held_q    <= 1'b0;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SPS_RESP_OKAY;
            ctrl_q       <= `SPS_CTRL_RESET;
        end else if (clk_en) begin
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_addr == `SPS_CTRL_OFFSET) begin
                    ctrl_q      <= sps_merge(ctrl_q, wr_data, wr_strb) &
                                   32'h0000_0001;
                    s_axi_bresp <= `SPS_RESP_OKAY;
                end else if (wr_addr == `SPS_STATUS_OFFSET ||
                             wr_addr == `SPS_STEP_COUNT_OFFSET ||
                             wr_addr == `SPS_PINS_OFFSET) begin
                    s_axi_bresp <= `SPS_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `SPS_RESP_SLVERR;
                end
            end else begin
                if (aw_go) begin
                    awaddr_q  <= s_axi_awaddr;
                    aw_held_q <= 1'b1;
                end
                if (w_go) begin
                    wdata_q  <= s_axi_wdata;
                    wstrb_q  <= s_axi_wstrb;
                    w_held_q <= 1'b1;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    always @* begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            `SPS_CTRL_OFFSET: begin
                rd_word = ctrl_q;
            end
            `SPS_STATUS_OFFSET: begin
                rd_word[`SPS_STAT_POS_MSB:`SPS_STAT_POS_LSB]   = pos_q;
                rd_word[`SPS_STAT_DRIVING]                     = driving;
                rd_word[`SPS_STAT_OVERHEAT:`SPS_STAT_OPEN]     = fault_q;
                rd_word[`SPS_STAT_ANY_FAULT]                   = any_fault;
                rd_word[`SPS_STAT_KIND_MSB:`SPS_STAT_KIND_LSB] = fault_kind_level;
            end
            `SPS_STEP_COUNT_OFFSET: begin
                rd_word = step_count_q;
            end
            `SPS_PINS_OFFSET: begin
                rd_word[`SPS_PIN_WIDTH-1:0] = pins_s;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SPS_RESP_OKAY;
        end else if (clk_en) begin
            if (ar_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

/* rtl/sps_defines.vh */
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// Register byte offsets on the AXI4-Lite slave.
`define SPS_CTRL_OFFSET        4'h0
`define SPS_STATUS_OFFSET      4'h4
`define SPS_STEP_COUNT_OFFSET  4'h8
`define SPS_PINS_OFFSET        4'hc

// Control register fields and reset value.
`define SPS_CTRL_SW_ENABLE     0
`define SPS_CTRL_COUNT_CLEAR   1
`define SPS_CTRL_RESET         32'h0000_0001

// Status register fields.
`define SPS_STAT_POS_LSB       0
`define SPS_STAT_POS_MSB       2
`define SPS_STAT_DRIVING       3
`define SPS_STAT_OPEN          4
`define SPS_STAT_OVERCURRENT   5
`define SPS_STAT_OVERHEAT      6
`define SPS_STAT_ANY_FAULT     7
`define SPS_STAT_KIND_LSB      8
`define SPS_STAT_KIND_MSB      9

// Synchronised pin vector layout.
`define SPS_PIN_STEP           0
`define SPS_PIN_EXCITE         1
`define SPS_PIN_EDGE           2
`define SPS_PIN_DIR            3
`define SPS_PIN_RESET_N        4
`define SPS_PIN_ENABLE         5
`define SPS_PIN_OPEN           6
`define SPS_PIN_OVERCURRENT    7
`define SPS_PIN_OVERHEAT       8
`define SPS_PIN_SUPPLY_LOW     9
`define SPS_PIN_WIDTH          10

// Sequence position after reset and fault-kind codes.
`define SPS_POS_INITIAL        3'h0
`define SPS_KIND_NONE          2'h0
`define SPS_KIND_OPEN          2'h1
`define SPS_KIND_OVERCURRENT   2'h2
`define SPS_KIND_OVERHEAT      2'h3

// AXI responses.
`define SPS_RESP_OKAY          2'h0
`define SPS_RESP_SLVERR        2'h2

`endif

/* rtl/sps_sync.v */
`timescale 1ns/1ps
`include "sps_defines.vh"

// Two-stage synchroniser for a bundle of asynchronous pins.
module sps_sync (
    clock,
    rst,
    clk_en,
    async_in,
    sync_out
);
    input  wire                      clock;
    input  wire                      rst;
    input  wire                      clk_en;
    input  wire [`SPS_PIN_WIDTH-1:0] async_in;
    output wire [`SPS_PIN_WIDTH-1:0] sync_out;

    reg [`SPS_PIN_WIDTH-1:0] meta_q;
    reg [`SPS_PIN_WIDTH-1:0] sync_q;

    // The first stage is read only by the second one.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_q <= {`SPS_PIN_WIDTH{1'b0}};
            sync_q <= {`SPS_PIN_WIDTH{1'b0}};
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

/* verification/sps_properties.sv */
`timescale 1ns/1ps
module sps_properties (
    input wire       clock, rst, clk_en, step_clk, sys_reset_n, output_enable, supply_low,
    input wire       open_detect, overcurrent_detect, overheat_detect, s_axi_wvalid,
    input wire       phase_one, phase_one_inverse, phase_two, phase_two_inverse,
    input wire       any_fault_n_out, any_fault_n_oe,
    input wire [1:0] fault_kind_level
);
    wire [3:0] ph = {phase_one, phase_one_inverse, phase_two, phase_two_inverse};
    // Anything that may move the phases keeps the hold window shut.
    wire       calm = clk_en && output_enable && sys_reset_n && !supply_low && !s_axi_wvalid
                      && !open_detect && !overcurrent_detect && !overheat_detect;
    default clocking dclk @(posedge clock);
    endclocking
    default disable iff (rst);
    // Pins pass a two-stage synchroniser, so every window allows for that lag.
    sequence s_enable_low; !output_enable [*5]; endsequence
    sequence s_reset_low; !sys_reset_n [*5]; endsequence
    sequence s_supply_low; supply_low [*5]; endsequence
    sequence s_open_held; (open_detect && sys_reset_n && !supply_low) [*6]; endsequence
    sequence s_latched; any_fault_n_oe [*2]; endsequence
    sequence s_quiet; ($stable(step_clk) && calm && !any_fault_n_oe) [*6]; endsequence
    property p_enable_off; s_enable_low |-> ph == 4'h0; endproperty
    property p_reset_off; s_reset_low |-> ph == 4'h0; endproperty
    property p_power_reset; s_supply_low |-> ph == 4'h0 && !any_fault_n_oe; endproperty
    property p_fault_latch; s_open_held |-> any_fault_n_oe; endproperty
    property p_fault_off; s_latched |-> ph == 4'h0 && fault_kind_level != 2'h0; endproperty
    property p_drain_low; any_fault_n_oe |-> !any_fault_n_out; endproperty
    property p_phase_legal; !(ph[3] && ph[2]) && !(ph[1] && ph[0]); endproperty
    property p_step_hold; s_quiet |-> $stable(ph); endproperty
    a_enable_off: assert property (p_enable_off) else $error("phase on, enable low");
    a_reset_off: assert property (p_reset_off) else $error("phase on in reset");
    a_power_reset: assert property (p_power_reset) else $error("power reset ignored");
    a_fault_latch: assert property (p_fault_latch) else $error("fault not flagged");
    a_fault_off: assert property (p_fault_off) else $error("fault kept drive");
    a_drain_low: assert property (p_drain_low) else $error("flag not driven low");
    a_phase_legal: assert property (p_phase_legal) else $error("phase pair clash");
    a_step_hold: assert property (p_step_hold) else $error("phase moved unasked");
endmodule

/* verification/sps_host_model.sv */
`timescale 1ns/1ps
// Host side. Times are scaled down so the run stays short.
module sps_host_model #(
    parameter SETUP_CYC = 6,
    parameter WIDTH_CYC = 12
) (
    input  wire clock,
    input  wire go,
    input  wire dir_in,
    input  wire excite_in,
    input  wire edge_in,
    output reg  busy,
    output reg  step_clk,
    output reg  rotation_dir,
    output reg  excitation_select,
    output reg  edge_select
);
    integer n;
    initial begin
        {busy, step_clk, rotation_dir, excitation_select} = 4'h0;
        edge_select = 1'b1;
        forever begin
            @(posedge clock);
            if (go) begin
                busy <= 1'b1;
                // Modes and direction move together, so no step edge falls between them.
                {excitation_select, edge_select} <= {excite_in, edge_in};
                rotation_dir <= dir_in;
                repeat (SETUP_CYC) @(posedge clock);
                step_clk <= ~step_clk;
                for (n = 0; n < WIDTH_CYC; n = n + 1)
                    @(posedge clock);
                busy <= 1'b0;
            end
        end
    end
endmodule

/* verification/test_stepper_phase_sequencer.sv */
`timescale 1ns/1ps
`include "sps_defines.vh"
module test_stepper_phase_sequencer;
    localparam [31:0] PH_TAB = 32'h1546_2a89;
    reg         clock, rst, sys_reset_n, output_enable, supply_low, go, dir_in, excite_in;
    reg         edge_in, open_detect, overcurrent_detect, overheat_detect, clk_en;
    reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    reg  [31:0] s_axi_wdata, rd_data;
    reg  [1:0]  rd_resp, wr_resp;
    reg  [15:0] lfsr;
    wire        busy, step_clk, rotation_dir, excitation_select, edge_select;
    wire        phase_one, phase_one_inverse, phase_two, phase_two_inverse;
    wire        any_fault_n_out, any_fault_n_oe, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire        s_axi_arready, s_axi_rvalid;
    wire [1:0]  fault_kind_level, s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     pos, i, err_total, check_count, cyc;

    sps_host_model #(.SETUP_CYC(6), .WIDTH_CYC(12)) sps_host_model_inst (
        .clock(clock), .go(go), .dir_in(dir_in), .excite_in(excite_in), .edge_in(edge_in),
        .busy(busy), .step_clk(step_clk), .rotation_dir(rotation_dir),
        .excitation_select(excitation_select), .edge_select(edge_select));

    sps_top sps_top_inst (
        .clock(clock), .rst(rst), .clk_en(clk_en), .step_clk(step_clk),
        .excitation_select(excitation_select), .edge_select(edge_select),
        .rotation_dir(rotation_dir), .sys_reset_n(sys_reset_n), .output_enable(output_enable),
        .open_detect(open_detect), .overcurrent_detect(overcurrent_detect),
        .overheat_detect(overheat_detect), .supply_low(supply_low), .phase_one(phase_one),
        .phase_one_inverse(phase_one_inverse), .phase_two(phase_two),
        .phase_two_inverse(phase_two_inverse), .any_fault_n_out(any_fault_n_out),
        .any_fault_n_oe(any_fault_n_oe), .fault_kind_level(fault_kind_level),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));

    function [15:0] lfsr_nx(input [15:0] v);
        lfsr_nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task end_sim;
        begin
            if (err_total == 0 && check_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    task check(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("Error at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask

    // Sampled on the falling edge, well clear of the synchroniser lag.
    task chk(input on, input oe, input [1:0] kind);
        begin
            repeat (6) @(posedge clock);
            @(negedge clock);
            check({28'h0, phase_one, phase_one_inverse, phase_two, phase_two_inverse},
                  on ? {28'h0, PH_TAB[pos*4 +: 4]} : 32'h0);
            check({31'h0, any_fault_n_oe}, {31'h0, oe});
            check({30'h0, fault_kind_level}, {30'h0, kind});
            check({31'h0, any_fault_n_oe & any_fault_n_out}, 32'h0);
            @(posedge clock);
        end
    endtask

    task step(input d, input m, input e);
        begin
            {dir_in, excite_in, edge_in, go} <= {d, m, e, 1'b1};
            @(posedge clock);
            go <= 1'b0;
            @(posedge clock);
            while (busy)
                @(posedge clock);
            if (step_clk || !e) begin
                if (m || pos % 2 == 1)
                    pos = (pos + (d ? 7 : 1)) % 8;
                else
                    pos = (pos + (d ? 6 : 2)) % 8;
            end
        end
    endtask

    task wr(input [3:0] a, input [31:0] d);
        reg aw_pend, w_pend;
        begin
            {s_axi_awaddr, s_axi_wdata} <= {a, d};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            {aw_pend, w_pend} = 2'h3;
            while (aw_pend || w_pend) begin
                @(posedge clock);
                if (aw_pend && s_axi_awready) begin
                    aw_pend = 1'b0;
                    s_axi_awvalid <= 1'b0;
                end
                if (w_pend && s_axi_wready) begin
                    w_pend = 1'b0;
                    s_axi_wvalid <= 1'b0;
                end
            end
            @(posedge clock);
            while (!s_axi_bvalid)
                @(posedge clock);
            wr_resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            @(posedge clock);
        end
    endtask

    task rd(input [3:0] a);
        begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            @(posedge clock);
            while (!s_axi_arready)
                @(posedge clock);
            s_axi_arvalid <= 1'b0;
            @(posedge clock);
            while (!s_axi_rvalid)
                @(posedge clock);
            {rd_resp, rd_data} = {s_axi_rresp, s_axi_rdata};
            s_axi_rready <= 1'b0;
            @(posedge clock);
        end
    endtask

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // A hang costs a mismatch and still ends in the closing report.
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_total = err_total + 1;
            end_sim;
        end
    end

    initial begin
        {rst, sys_reset_n, output_enable, edge_in, clk_en} = 5'h1f;
        s_axi_wstrb = 4'hf;
        {go, dir_in, excite_in, supply_low, open_detect, overcurrent_detect} = 6'h0;
        {overheat_detect, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
        {err_total, check_count, cyc, pos} = 128'h0;
        lfsr = 16'h7628;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        chk(1'b1, 1'b0, 2'h0);
        rd(`SPS_CTRL_OFFSET);
        check(rd_data, 32'h1);
        for (i = 0; i < 48; i = i + 1) begin
            repeat (i) @(posedge clock);
            lfsr = lfsr_nx(lfsr);
            step(lfsr[0], lfsr[1], lfsr[2]);
            chk(1'b1, 1'b0, 2'h0);
            rd(`SPS_STATUS_OFFSET);
            check({29'h0, rd_data[2:0]}, pos);
        end
        output_enable <= 1'b0;
        step(1'b0, 1'b1, 1'b0);
        chk(1'b0, 1'b0, 2'h0);
        step(1'b1, 1'b0, 1'b0);
        output_enable <= 1'b1;
        chk(1'b1, 1'b0, 2'h0);
        // With the clock enable low a step edge must wait until it returns.
        clk_en <= 1'b0;
        step(1'b0, 1'b1, 1'b0);
        pos = (pos + 7) % 8;
        chk(1'b1, 1'b0, 2'h0);
        clk_en <= 1'b1;
        pos = (pos + 1) % 8;
        chk(1'b1, 1'b0, 2'h0);
        wr(`SPS_CTRL_OFFSET, 32'h2);
        chk(1'b0, 1'b0, 2'h0);
        rd(`SPS_STEP_COUNT_OFFSET);
        check(rd_data, 32'h0);
        wr(`SPS_CTRL_OFFSET, 32'h1);
        rd(`SPS_CTRL_OFFSET);
        check(rd_data, 32'h1);
        s_axi_wstrb <= 4'he;
        wr(`SPS_CTRL_OFFSET, 32'h0);
        s_axi_wstrb <= 4'hf;
        rd(`SPS_CTRL_OFFSET);
        check(rd_data, 32'h1);
        wr(`SPS_STATUS_OFFSET, 32'hff);
        check({30'h0, wr_resp}, {30'h0, `SPS_RESP_OKAY});
        rd(4'h2);
        check({30'h0, rd_resp}, {30'h0, `SPS_RESP_SLVERR});
        for (i = 1; i < 4; i = i + 1) begin
            {overheat_detect, overcurrent_detect, open_detect} <= 3'h1 << (i - 1);
            repeat (6) @(posedge clock);
            {overheat_detect, overcurrent_detect, open_detect} <= 3'h0;
            chk(1'b0, 1'b1, i[1:0]);
            step(1'b1, 1'b0, 1'b1);
            sys_reset_n <= 1'b0;
            chk(1'b0, 1'b1, i[1:0]);
            sys_reset_n <= 1'b1;
            repeat (20) @(posedge clock);
            pos = 0;
            chk(1'b1, 1'b0, 2'h0);
        end
        step(1'b0, 1'b1, 1'b1);
        open_detect <= 1'b1;
        repeat (6) @(posedge clock);
        open_detect <= 1'b0;
        {output_enable, supply_low} <= 2'h1;
        chk(1'b0, 1'b0, 2'h0);
        {output_enable, supply_low} <= 2'h2;
        pos = 0;
        chk(1'b1, 1'b0, 2'h0);
        end_sim;
    end
endmodule

bind sps_top sps_properties sps_properties_inst (
    .clock(clock), .rst(rst), .clk_en(clk_en), .step_clk(step_clk), .sys_reset_n(sys_reset_n),
    .output_enable(output_enable), .supply_low(supply_low), .open_detect(open_detect),
    .overcurrent_detect(overcurrent_detect), .overheat_detect(overheat_detect),
    .s_axi_wvalid(s_axi_wvalid), .phase_one(phase_one), .phase_one_inverse(phase_one_inverse),
    .phase_two(phase_two), .phase_two_inverse(phase_two_inverse),
    .any_fault_n_out(any_fault_n_out), .any_fault_n_oe(any_fault_n_oe),
    .fault_kind_level(fault_kind_level));
